/* rtl/iww_pkg.sv */
// shared constants and types of the internal windowed watchdog
package iww_pkg;
  localparam int unsigned CNT_W            = 16;
  localparam logic [15:0] CNT_RST          = 16'h0000;
  localparam logic [15:0] TIMEOUT_RST      = 16'hffff;
  localparam logic [15:0] WIN_LO_RST       = 16'h0000;
  localparam logic [15:0] WIN_HI_RST       = 16'hffff;
  localparam logic [7:0]  SERVICE_KEY      = 8'ha5;
  localparam logic        RESP_SEL_RST     = 1'b0;
  localparam int unsigned RST_PULSE_NS     = 64;
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned RST_PULSE_CYC    = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // software configuration of the watchdog
  typedef struct packed {
    logic        windowed_watchdog_mode;
    logic        interrupt_response_select;
    logic [15:0] timeout;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
  } iww_cfg_t;

  typedef enum logic [1:0] {
    IWW_FAIL_NONE,
    IWW_FAIL_TIMEOUT,
    IWW_FAIL_EARLY,
    IWW_FAIL_BADKEY
  } iww_fail_t;
endpackage : iww_pkg

/* rtl/iww_watchdog.sv */
// internal watchdog with normal and windowed modes
// Functional notes
// - exactly one mode: normal or windowed
// - normal: expiry or wrong key is failure
// - normal failure gives reset or interrupt
// - comes up enabled in normal mode
// - windowed: missed window or wrong key fails
// - windowed failure gives reset or interrupt
// - control bit selects interrupt over reset
`timescale 1ns/1ps
`default_nettype none
module iww_watchdog
  import iww_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 arst_n_i,
  // configuration
  input  wire iww_pkg::iww_cfg_t    cfg_i,
  // service key write
  input  wire logic                 key_wr_i,
  input  wire logic [7:0]           key_i,
  // responses and status
  output logic                      warm_rst_o,
  output logic                      irq_o,
  output logic [CNT_W-1:0]          count_o,
  output iww_pkg::iww_fail_t        fail_cause_o
);
  import iww_pkg::*;

  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              key_ok;
  logic              key_bad;
  logic              early;
  logic              expired;
  logic              fail;
  iww_fail_t         cause;
  logic [7:0]        rst_cnt_r;
  logic [7:0]        warm_len_r;

  // =====================================================
  // failure detection
  assign key_ok  = key_wr_i && (key_i == SERVICE_KEY);
  assign key_bad = key_wr_i && (key_i != SERVICE_KEY);
  // windowed mode selected by one bit, so modes are exclusive
  assign early   = cfg_i.windowed_watchdog_mode && key_ok && (cnt_r < cfg_i.win_lo);
  assign expired = cfg_i.windowed_watchdog_mode ? (cnt_r >= cfg_i.win_hi)
                                                : (cnt_r >= cfg_i.timeout);
  assign fail    = key_bad || early || expired;

  always_comb
  begin
    cause = IWW_FAIL_NONE;
    if (key_bad)
    begin
      cause = IWW_FAIL_BADKEY;
    end
    else if (early)
    begin
      cause = IWW_FAIL_EARLY;
    end
    else if (expired)
    begin
      cause = IWW_FAIL_TIMEOUT;
    end
  end

  // =====================================================
  // timeout counter
  always_comb
  begin
    if (fail || key_ok)
    begin
      cnt_nxt = CNT_RST;
    end
    else
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // enabled from reset, counting in normal mode
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r <= CNT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // =====================================================
  // error response
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_cnt_r  <= 8'h00;
      warm_rst_o <= 1'b0;
    end
    else if (fail && !cfg_i.interrupt_response_select)
    begin
      rst_cnt_r  <= 8'(RST_PULSE_CYC - 1);
      warm_rst_o <= 1'b1;
    end
    else if (rst_cnt_r != 8'h00)
    begin
      rst_cnt_r  <= rst_cnt_r - 8'h01;
    end
    else
    begin
      warm_rst_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= fail && cfg_i.interrupt_response_select;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_o      <= CNT_RST;
      fail_cause_o <= IWW_FAIL_NONE;
    end
    else
    begin
      count_o <= cnt_nxt;
      if (fail)
      begin
        fail_cause_o <= cause;
      end
    end
  end

  // =====================================================
  // assertions and the pulse tracker they read
  // cycles the warm reset has stood since its last trigger
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      warm_len_r <= 8'h00;
    end
    else if (fail && !cfg_i.interrupt_response_select)
    begin
      warm_len_r <= 8'h01;
    end
    else if (warm_rst_o)
    begin
      warm_len_r <= warm_len_r + 8'h01;
    end
    else
    begin
      warm_len_r <= 8'h00;
    end
  end

  bad_key_resp_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    key_bad |=> (warm_rst_o || irq_o))
    else $error("bad key gave no response");

  expiry_resp_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (!cfg_i.windowed_watchdog_mode && cnt_r >= cfg_i.timeout) |=> (warm_rst_o || irq_o))
    else $error("normal expiry gave no response");

  normal_key_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (!cfg_i.windowed_watchdog_mode && key_ok && cnt_r < cfg_i.timeout)
    |=> !irq_o && fail_cause_o == $past(fail_cause_o))
    else $error("timely key in normal mode failed");

  reset_sel_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (fail && !cfg_i.interrupt_response_select) |=> warm_rst_o && !irq_o)
    else $error("reset response missing");

  irq_sel_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (fail && cfg_i.interrupt_response_select) |=> irq_o)
    else $error("interrupt response missing");

  irq_pulse_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (irq_o && !(fail && cfg_i.interrupt_response_select)) |=> !irq_o)
    else $error("interrupt stood too long");

  early_key_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (cfg_i.windowed_watchdog_mode && key_ok && cnt_r < cfg_i.win_lo) |=> fail_cause_o == IWW_FAIL_EARLY)
    else $error("early key not flagged");

  window_key_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (cfg_i.windowed_watchdog_mode && key_ok && cnt_r >= cfg_i.win_lo && cnt_r < cfg_i.win_hi)
    |=> !irq_o && fail_cause_o == $past(fail_cause_o))
    else $error("key inside window failed");

  window_miss_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (cfg_i.windowed_watchdog_mode && !key_wr_i && cnt_r >= cfg_i.win_hi) |=> fail_cause_o == IWW_FAIL_TIMEOUT)
    else $error("window miss not flagged");

  good_key_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    key_ok |=> cnt_r == CNT_RST && count_o == CNT_RST)
    else $error("good key did not restart");

  count_step_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !fail && !key_wr_i |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter stalled");

  pulse_len_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (warm_rst_o && warm_len_r < 8'(RST_PULSE_CYC)) |=> warm_rst_o)
    else $error("reset pulse too short");

  pulse_end_a : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (warm_len_r == 8'(RST_PULSE_CYC) && !(fail && !cfg_i.interrupt_response_select)) |=> !warm_rst_o)
    else $error("reset pulse too long");

  normal_expiry_c : cover property (@(posedge clock_i) disable iff (!arst_n_i)
    !cfg_i.windowed_watchdog_mode && expired);
  window_service_c : cover property (@(posedge clock_i) disable iff (!arst_n_i)
    cfg_i.windowed_watchdog_mode && key_ok && !early && !expired);
  early_fail_c : cover property (@(posedge clock_i) disable iff (!arst_n_i)
    early && cfg_i.interrupt_response_select);
  bad_key_c : cover property (@(posedge clock_i) disable iff (!arst_n_i)
    key_bad && cfg_i.windowed_watchdog_mode);
  irq_path_c : cover property (@(posedge clock_i) disable iff (!arst_n_i) $rose(irq_o));
endmodule : iww_watchdog
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the internal windowed watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("unexpected %0t bad value", $time); end end
module tb_top;
  import iww_pkg::*;
  logic             clock_i = 1'b0, arst_n_i = 1'b0, key_wr_i = 1'b0;
  logic [7:0]       key_i = 8'h00, k;
  iww_cfg_t         cfg_i = '0;
  logic             warm_rst_o, irq_o;
  logic [CNT_W-1:0] count_o, th, lo, kat;
  iww_fail_t        fail_cause_o;
  int               err_count = 0, check_count = 0, cyc = 0;

  iww_watchdog u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .cfg_i(cfg_i), .key_wr_i(key_wr_i),
    .key_i(key_i), .warm_rst_o(warm_rst_o), .irq_o(irq_o), .count_o(count_o), .fail_cause_o(fail_cause_o));

  initial forever #2 clock_i = ~clock_i;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  function automatic iww_fail_t exp_cause(input logic w, input logic [15:0] lo, kat, th, input logic [7:0] k);
    if (kat == th) return IWW_FAIL_TIMEOUT;
    if (k != SERVICE_KEY) return IWW_FAIL_BADKEY;
    if (w && kat < lo) return IWW_FAIL_EARLY;
    return IWW_FAIL_NONE;
  endfunction : exp_cause

  // ==========================================
  // one run: reset, optional key, then failure
  task automatic run(input logic w, s);
    iww_fail_t c;
    logic [15:0] tg;
    int n;
    int r;
    c = exp_cause(w, lo, kat, th, k);
    tg = kat;
    r = 0;
    @(negedge clock_i) arst_n_i = 1'b0;
    cfg_i = '{w, s, th, lo, th};
    @(negedge clock_i)
    `CHK({warm_rst_o, irq_o, count_o, fail_cause_o}, '0)
    arst_n_i = 1'b1;
    @(negedge clock_i);
    `CHK(count_o, 16'h0001)
    while (r < 2)
    begin
      n = 0;
      while (count_o !== tg && n < 2000)
      begin
        @(negedge clock_i);
        n++;
      end
      `CHK(count_o, tg)
      key_wr_i = (r == 0 && kat != th);
      key_i = k;
      @(negedge clock_i) key_wr_i = 1'b0;
      `CHK(count_o, 16'h0000)
      `CHK(warm_rst_o, c != IWW_FAIL_NONE && !s)
      `CHK(irq_o, c != IWW_FAIL_NONE && s)
      r++;
      if (c == IWW_FAIL_NONE)
      begin
        `CHK(fail_cause_o, IWW_FAIL_NONE)
        tg = th;
        c = IWW_FAIL_TIMEOUT;
      end
      else
      begin
        `CHK(fail_cause_o, c)
        repeat (RST_PULSE_CYC - 1) @(negedge clock_i);
        `CHK({warm_rst_o, irq_o}, {!s, 1'b0})
        @(negedge clock_i);
        `CHK(warm_rst_o, 1'b0)
        r = 2;
      end
    end
  endtask : run

  initial
  begin
    void'($urandom(32'h3add));
    repeat (20) @(negedge clock_i);
    for (int i = 0; i < 16; i++)
    begin
      th = 16'($urandom_range(40, 300));
      lo = 16'($urandom_range(10, 30));
      k = (i % 4 == 3) ? SERVICE_KEY ^ 8'($urandom_range(1, 255)) : SERVICE_KEY;
      case (i % 4)
        0: kat = th;
        1: kat = lo;
        2: kat = lo - 16'h0001;
        default: kat = lo + 16'h0005;
      endcase
      run(i[2], i[3]);
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
